// File: spe_pkg.sv
// Purpose: shared constants for the serial port error and discard block
// Assumes: 10 MHz system clock, registers one word each
// Notes:   offsets are word byte addresses
package spe_pkg;
    localparam logic [7:0] SPE_ADDR_STATUS  = 8'h00;
    localparam logic [7:0] SPE_ADDR_DETECT  = 8'h04;
    localparam logic [7:0] SPE_ADDR_CTRL    = 8'h08;
    localparam logic [7:0] SPE_ADDR_THRESH  = 8'h0c;
    localparam logic [7:0] SPE_ADDR_RATE    = 8'h10;
    localparam logic [7:0] SPE_ADDR_IRQ_ST  = 8'h14;
    localparam logic [7:0] SPE_ADDR_IRQ_MSK = 8'h18;
    localparam logic [7:0] SPE_ADDR_LANES   = 8'h1c;

    // status register bits (even port in low byte, odd port in the byte above)
    localparam int SPE_ST_PORT_ERR   = 0;
    localparam int SPE_ST_PW_PEND    = 1;
    localparam int SPE_ST_LINK_OK    = 2;
    localparam int SPE_ST_UNINIT     = 3;
    localparam int SPE_ST_ERR_STOP   = 4;
    localparam int SPE_ST_DISCARD    = 5;
    localparam int SPE_ST_ODD_ERR    = 8;
    localparam int SPE_ST_ODD_PEND   = 9;
    // detect register bits
    localparam int SPE_DT_VENDOR     = 0;
    localparam int SPE_DT_EVEN_ERR   = 1;
    // control register bits
    localparam int SPE_CT_ERR_RPT_EN = 0;
    localparam int SPE_CT_PORTWRITE_DISABLE     = 1;
    localparam int SPE_CT_DROP_EN    = 2;
    localparam int SPE_CT_STOP_EN    = 3;
    localparam int SPE_CT_DEAD_EN    = 4;
    localparam int SPE_CT_LOCKOUT    = 5;
    localparam int SPE_CT_SINGLE     = 6;
    localparam int SPE_CT_SPLIT      = 7;
    // interrupt bits
    localparam int SPE_IRQ_PORT_ERR  = 0;
    localparam int SPE_IRQ_RATE_FAIL = 1;
    localparam int SPE_IRQ_DEAD      = 2;
    localparam int SPE_IRQ_MISMATCH  = 3;

    localparam int SPE_IRQ_W  = 4;
    localparam int SPE_RATE_W = 8;
    localparam int SPE_LANES  = 4;

    localparam logic [7:0] SPE_CTRL_RST   = 8'h01;
    localparam logic [7:0] SPE_THRESH_RST = 8'hff;

    // discovery and dead-link timing
    localparam int SPE_CLK_KHZ       = 10000;
    localparam int SPE_DISCOVERY_US  = 12;
    localparam int SPE_DISCOVERY_CYC = (SPE_DISCOVERY_US * SPE_CLK_KHZ + 999) / 1000;
    localparam int SPE_DEAD_US       = 100;
    localparam int SPE_DEAD_CYC      = (SPE_DEAD_US * SPE_CLK_KHZ) / 1000;
    localparam int SPE_TMR_W         = 16;

    typedef enum logic [2:0]
    {
        SPE_LINK_UNINIT,
        SPE_LINK_DISCOVER,
        SPE_LINK_SILENT,
        SPE_LINK_INIT1X,
        SPE_LINK_OK
    } spe_link_e;
endpackage

// File: spe_sync.sv
// Purpose: two flip-flop synchroniser for a bus of levels
// Assumes: inputs come from another clock domain
// Notes:   first stage is read by the second only
`timescale 1ns/1ns
module spe_sync #(
    parameter int W = 1
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed
    {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } spe_sync_s;

    spe_sync_s st_ff;
    spe_sync_s nxt_st;

    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.meta = i_async;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign o_sync = st_ff.sync;
endmodule

// File: spe_port.sv
// Purpose: port error flags, port-write requests and outbound discard
// Assumes: lane signal, sync, error and link clock come from pins; rest is local
// Notes:   register port with one-cycle read latency; level interrupt
//
// Overview of operation
// - single-lane port retries after partner discovery timeout
// - signal lost in discovery then back in silence sets error
// - port error also sets vendor fault flag
// - error flags never block traffic at link OK
// - odd port error also flags even port in split mode
// - even flag ORs error causes of four lanes
// - lane causes qualified by lane code-group sync
// - even flag harmless; written zero clears it
// - enabled odd error makes both ports port-write
// - rate counter over threshold triggers port-write
// - drop and stop enables discard above threshold
// - dead-link expiry discards until link reinitialized
// - threshold discard keeps working after reinitialization
// - ackID mismatch stops output, ends threshold discard
// - lockout keeps discard across reinitialization
`timescale 1ns/1ns
module spe_port
    import spe_pkg::*;
#(
    parameter int DEAD_CYC = SPE_DEAD_CYC
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst,
    input  wire logic [7:0]           i_addr,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [31:0]          o_rdata,
    input  wire logic [SPE_LANES-1:0] i_lane_signal,
    input  wire logic [SPE_LANES-1:0] i_lane_sync,
    input  wire logic [SPE_LANES-1:0] i_lane_err,
    input  wire logic                 i_link_clk,
    input  wire logic                 i_odd_err,
    input  wire logic                 i_rate_event,
    input  wire logic                 i_ackid_mismatch,
    input  wire logic                 i_err_stop_clear,
    input  wire logic                 i_pkt_valid,
    output logic                      o_pkt_ready,
    output logic                      o_pkt_drop,
    output logic                      o_pw_even,
    output logic                      o_pw_odd,
    output logic                      o_link_ok,
    output logic                      o_irq
);
    typedef struct packed
    {
        spe_link_e             link;
        logic [SPE_TMR_W-1:0]  tmr;
        logic                  seen_sig;
        logic                  lost_sig;
        logic                  port_err;
        logic                  odd_err;
        logic                  vendor;
        logic                  even_err;
        logic                  pend_even;
        logic                  pend_odd;
        logic                  err_stop;
        logic                  dead;
        logic [7:0]            ctrl;
        logic [SPE_RATE_W-1:0] thresh;
        logic [SPE_RATE_W-1:0] rate;
        logic [SPE_IRQ_W-1:0]  irq_st;
        logic [SPE_IRQ_W-1:0]  irq_msk;
        logic                  odd_err_d;
        logic                  rate_fail_d;
        logic                  lclk_d;
        logic                  pw_even;
        logic                  pw_odd;
        logic [31:0]           rdata;
    } spe_port_s;

    spe_port_s st_ff;
    spe_port_s nxt_st;

    logic [SPE_LANES-1:0] lane_sig_s;
    logic [SPE_LANES-1:0] lane_sync_s;
    logic [SPE_LANES-1:0] lane_err_s;
    logic                 lclk_s;

    spe_sync #(
        .W (3 * SPE_LANES + 1)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async ({i_lane_signal, i_lane_sync, i_lane_err, i_link_clk}),
        .o_sync  ({lane_sig_s, lane_sync_s, lane_err_s, lclk_s})
    );

    function automatic logic wr_at(input logic [7:0] a);
        return i_wr && (i_addr == a);
    endfunction

    logic rate_fail;
    logic std_discard;
    logic discard;
    logic lane_cause;
    logic any_sig;
    logic all_sig;
    logic lclk_rise;
    logic [SPE_IRQ_W-1:0] irq_ev;

    always_comb
    begin
        any_sig     = |lane_sig_s;
        all_sig     = &lane_sig_s;
        lclk_rise   = lclk_s && !st_ff.lclk_d;
        lane_cause  = |(lane_err_s & lane_sync_s);
        rate_fail   = st_ff.rate > st_ff.thresh;
        std_discard = st_ff.ctrl[SPE_CT_DROP_EN] && st_ff.ctrl[SPE_CT_STOP_EN]
                      && rate_fail && !st_ff.err_stop;
        discard     = std_discard || st_ff.dead || st_ff.ctrl[SPE_CT_LOCKOUT];
    end

    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.lclk_d  = lclk_s;
        nxt_st.odd_err_d   = st_ff.odd_err;
        nxt_st.rate_fail_d = rate_fail;
        nxt_st.pw_even = 1'b0;
        nxt_st.pw_odd  = 1'b0;
        nxt_st.rdata   = '0;
        irq_ev         = '0;

        // link start-up
        case (st_ff.link)
            SPE_LINK_UNINIT:
            begin
                nxt_st.tmr = '0;
                if (any_sig)
                begin
                    nxt_st.seen_sig = 1'b1;
                    nxt_st.link     = SPE_LINK_DISCOVER;
                end
            end
            SPE_LINK_DISCOVER:
            begin
                nxt_st.tmr = st_ff.tmr + 1'b1;
                if (!any_sig && st_ff.seen_sig)
                begin
                    nxt_st.lost_sig = 1'b1;
                    nxt_st.tmr      = '0;
                    nxt_st.link     = SPE_LINK_SILENT;
                end
                else if (st_ff.ctrl[SPE_CT_SINGLE] && !all_sig
                         && st_ff.tmr >= SPE_TMR_W'(SPE_DISCOVERY_CYC - 1))
                begin
                    nxt_st.tmr  = '0;
                    nxt_st.link = SPE_LINK_SILENT;
                end
                else if (all_sig && !st_ff.ctrl[SPE_CT_SINGLE])
                    nxt_st.link = SPE_LINK_OK;
            end
            SPE_LINK_SILENT:
            begin
                nxt_st.tmr = '0;
                if (any_sig)
                    nxt_st.link = SPE_LINK_INIT1X;
            end
            SPE_LINK_INIT1X:
            begin
                if (!any_sig)
                    nxt_st.link = SPE_LINK_SILENT;
                else if (lane_sync_s[0] && lclk_rise)
                    nxt_st.link = SPE_LINK_OK;
            end
            SPE_LINK_OK:
            begin
                nxt_st.lost_sig = 1'b0;
                if (!any_sig)
                    nxt_st.link = SPE_LINK_UNINIT;
            end
            default:
                nxt_st.link = SPE_LINK_UNINIT;
        endcase

        // dead-link timer, ends on reinitialization
        if (st_ff.link == SPE_LINK_OK)
        begin
            nxt_st.dead = 1'b0;
            if (lclk_rise)
                nxt_st.tmr = '0;
            else if (st_ff.ctrl[SPE_CT_DEAD_EN] && !st_ff.dead)
            begin
                nxt_st.tmr = st_ff.tmr + 1'b1;
                if (st_ff.tmr >= SPE_TMR_W'(DEAD_CYC - 1))
                begin
                    nxt_st.dead      = 1'b1;
                    nxt_st.link      = SPE_LINK_UNINIT;
                    irq_ev[SPE_IRQ_DEAD] = 1'b1;
                end
            end
        end

        // error-rate counter
        if (i_rate_event && st_ff.rate != '1)
            nxt_st.rate = st_ff.rate + 1'b1;

        // output error-stopped on ackID mismatch until cleared; mismatch wins
        if (i_err_stop_clear)
            nxt_st.err_stop = 1'b0;
        if (i_ackid_mismatch)
        begin
            nxt_st.err_stop = 1'b1;
            irq_ev[SPE_IRQ_MISMATCH] = 1'b1;
        end

        // software writes; hardware sets below win
        if (wr_at(SPE_ADDR_STATUS))
        begin
            if (i_wdata[SPE_ST_PORT_ERR])
                nxt_st.port_err = 1'b0;
            if (i_wdata[SPE_ST_PW_PEND])
                nxt_st.pend_even = 1'b0;
            if (i_wdata[SPE_ST_ODD_ERR])
                nxt_st.odd_err = 1'b0;
            if (i_wdata[SPE_ST_ODD_PEND])
                nxt_st.pend_odd = 1'b0;
        end
        if (wr_at(SPE_ADDR_DETECT))
        begin
            if (!i_wdata[SPE_DT_VENDOR])
                nxt_st.vendor = 1'b0;
            if (!i_wdata[SPE_DT_EVEN_ERR])
                nxt_st.even_err = 1'b0;
        end
        if (wr_at(SPE_ADDR_CTRL))
            nxt_st.ctrl = i_wdata[7:0];
        if (wr_at(SPE_ADDR_THRESH))
            nxt_st.thresh = i_wdata[SPE_RATE_W-1:0];
        if (wr_at(SPE_ADDR_RATE))
            nxt_st.rate = i_wdata[SPE_RATE_W-1:0];
        if (wr_at(SPE_ADDR_IRQ_MSK))
            nxt_st.irq_msk = i_wdata[SPE_IRQ_W-1:0];

        // error sets
        // signal back after a lost one in silence; set wins over clear
        if (st_ff.link == SPE_LINK_SILENT && any_sig && st_ff.lost_sig)
        begin
            nxt_st.port_err = 1'b1;
        end
        if (i_odd_err)
            nxt_st.odd_err = 1'b1;
        if (st_ff.ctrl[SPE_CT_SPLIT] && (i_odd_err || lane_cause))
            nxt_st.even_err = 1'b1;
        if (st_ff.port_err || nxt_st.port_err)
            nxt_st.vendor = 1'b1;
        if (nxt_st.port_err && !st_ff.port_err)
            irq_ev[SPE_IRQ_PORT_ERR] = 1'b1;

        // port-write requests
        if (st_ff.odd_err && !st_ff.odd_err_d && st_ff.ctrl[SPE_CT_SPLIT]
            && st_ff.ctrl[SPE_CT_ERR_RPT_EN] && !st_ff.ctrl[SPE_CT_PORTWRITE_DISABLE])
        begin
            nxt_st.pw_even   = 1'b1;
            nxt_st.pw_odd    = 1'b1;
            nxt_st.pend_even = 1'b1;
            nxt_st.pend_odd  = 1'b1;
        end
        if (rate_fail && !st_ff.rate_fail_d)
        begin
            irq_ev[SPE_IRQ_RATE_FAIL] = 1'b1;
            if (!st_ff.ctrl[SPE_CT_PORTWRITE_DISABLE])
            begin
                nxt_st.pw_even   = 1'b1;
                nxt_st.pend_even = 1'b1;
            end
        end

        // interrupt status, write one to clear, set wins
        nxt_st.irq_st = st_ff.irq_st;
        if (wr_at(SPE_ADDR_IRQ_ST))
            nxt_st.irq_st = st_ff.irq_st & ~i_wdata[SPE_IRQ_W-1:0];
        nxt_st.irq_st = nxt_st.irq_st | irq_ev;

        // read data, one cycle later
        if (i_rd)
        begin
            case (i_addr)
                SPE_ADDR_STATUS:
                begin
                    nxt_st.rdata[SPE_ST_PORT_ERR] = st_ff.port_err;
                    nxt_st.rdata[SPE_ST_PW_PEND]  = st_ff.pend_even;
                    nxt_st.rdata[SPE_ST_LINK_OK]  = st_ff.link == SPE_LINK_OK;
                    nxt_st.rdata[SPE_ST_UNINIT]   = st_ff.link != SPE_LINK_OK;
                    nxt_st.rdata[SPE_ST_ERR_STOP] = st_ff.err_stop;
                    nxt_st.rdata[SPE_ST_DISCARD]  = discard;
                    nxt_st.rdata[SPE_ST_ODD_ERR]  = st_ff.odd_err;
                    nxt_st.rdata[SPE_ST_ODD_PEND] = st_ff.pend_odd;
                end
                SPE_ADDR_DETECT:
                begin
                    nxt_st.rdata[SPE_DT_VENDOR]   = st_ff.vendor;
                    nxt_st.rdata[SPE_DT_EVEN_ERR] = st_ff.even_err;
                end
                SPE_ADDR_CTRL:    nxt_st.rdata[7:0] = st_ff.ctrl;
                SPE_ADDR_THRESH:  nxt_st.rdata[SPE_RATE_W-1:0] = st_ff.thresh;
                SPE_ADDR_RATE:    nxt_st.rdata[SPE_RATE_W-1:0] = st_ff.rate;
                SPE_ADDR_IRQ_ST:  nxt_st.rdata[SPE_IRQ_W-1:0] = st_ff.irq_st;
                SPE_ADDR_IRQ_MSK: nxt_st.rdata[SPE_IRQ_W-1:0] = st_ff.irq_msk;
                SPE_ADDR_LANES:
                    nxt_st.rdata[2*SPE_LANES-1:0] = {lane_sync_s, lane_sig_s};
                default:          nxt_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            st_ff         <= '0;
            st_ff.link    <= SPE_LINK_UNINIT;
            st_ff.ctrl    <= SPE_CTRL_RST;
            st_ff.thresh  <= SPE_THRESH_RST;
        end
        else
            st_ff <= nxt_st;
    end

    // error flags never gate traffic, only discard and link state do
    assign o_pkt_ready = (st_ff.link == SPE_LINK_OK) || discard;
    assign o_pkt_drop  = i_pkt_valid && discard;
    assign o_pw_even   = st_ff.pw_even;
    assign o_pw_odd    = st_ff.pw_odd;
    assign o_link_ok   = st_ff.link == SPE_LINK_OK;
    assign o_irq       = |(st_ff.irq_st & st_ff.irq_msk);
    assign o_rdata     = st_ff.rdata;
endmodule

// File: spe_checker.sv
// Purpose: port assertions, error and discard block
// Assumes: shadows of lockout and mask follow bus writes
// Notes:   bind below the module
`timescale 1ns/1ns
module spe_checker
    import spe_pkg::*;
(
    input wire logic                 i_mclk,
    input wire logic                 i_rst,
    input wire logic [7:0]           i_addr,
    input wire logic [31:0]          i_wdata,
    input wire logic                 i_wr,
    input wire logic [SPE_LANES-1:0] i_lane_signal,
    input wire logic                 i_odd_err,
    input wire logic                 i_pkt_valid,
    input wire logic                 o_pkt_ready,
    input wire logic                 o_pkt_drop,
    input wire logic                 o_pw_even,
    input wire logic                 o_pw_odd,
    input wire logic                 o_link_ok,
    input wire logic                 o_irq
);
    typedef struct packed {logic lock; logic [SPE_IRQ_W-1:0] msk;} spe_chk_s;
    spe_chk_s st_ff;
    spe_chk_s nxt_st;
    always_comb
    begin
        nxt_st = st_ff;
        if (i_wr && i_addr == SPE_ADDR_CTRL)
            nxt_st.lock = i_wdata[SPE_CT_LOCKOUT];
        if (i_wr && i_addr == SPE_ADDR_IRQ_MSK)
            nxt_st.msk = i_wdata[SPE_IRQ_W-1:0];
    end
    always_ff @(posedge i_mclk)
        st_ff <= i_rst ? '0 : nxt_st;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_pw_start;
        $rose(o_pw_odd);
    endsequence
    sequence s_locked;
        st_ff.lock && i_pkt_valid;
    endsequence
    a_pw_cause: assert property (s_pw_start |-> $past(i_odd_err, 2))
        else $error("odd port-write without odd error");
    a_pw_pair: assert property (o_pw_odd |-> o_pw_even)
        else $error("odd port-write without even one");
    a_pw_width: assert property (o_pw_odd |=> !o_pw_odd)
        else $error("port-write pulse too long");
    a_lock_drop: assert property (s_locked |-> o_pkt_drop)
        else $error("packet passed under lockout");
    a_drop_qual: assert property (o_pkt_drop |-> i_pkt_valid && o_pkt_ready)
        else $error("drop without offered packet");
    a_ready_ok: assert property (o_link_ok |-> o_pkt_ready)
        else $error("traffic blocked at link ok");
    a_link_cause: assert property ($rose(o_link_ok) |-> $past(i_lane_signal, 2) != '0)
        else $error("link up without lane signal");
    a_irq_mask: assert property ((st_ff.msk == '0) [*2] |-> !o_irq)
        else $error("interrupt while fully masked");
endmodule

bind spe_port spe_checker u_chk (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_lane_signal,
    .i_odd_err, .i_pkt_valid, .o_pkt_ready, .o_pkt_drop, .o_pw_even, .o_pw_odd, .o_link_ok,
    .o_irq);

// File: spe_partner.sv
// Purpose: four-lane link partner falling back to one lane
// Assumes: bench starts it, may freeze its clock or add lane errors
// Notes:   link clock 800 ns, still while untrained
`timescale 1ns/1ns
module spe_partner (
    input  wire logic       i_start,
    input  wire logic       i_hold,
    input  wire logic [3:0] i_err,
    input  wire logic [3:0] i_sync_on,
    output logic      [3:0] o_signal,
    output logic      [3:0] o_sync,
    output logic      [3:0] o_err,
    output logic            o_link_clk
);
    logic up = 1'b0;
    initial
    begin
        o_signal = 4'h0;
        o_link_clk = 1'b0;
        #137;
        forever
        begin
            #400;
            if (up && !i_hold)
                o_link_clk = ~o_link_clk;
        end
    end
    always @(posedge i_start)
    begin
        up = 1'b0;
        o_signal = 4'hf;
        #15000;
        o_signal = 4'h0;
        #6000;
        o_signal = 4'h1;
        #2000;
        up = 1'b1;
    end
    assign o_sync = {3'b000, up} | i_sync_on;
    assign o_err  = i_err;
endmodule

// File: spe_port_bench.sv
// Purpose: self-checking bench, error and discard block
// Assumes: dead-link count cut to 20 cycles
// Notes:   expectations from m_thr and fixed codes
`timescale 1ns/1ns
module spe_port_bench;
    import spe_pkg::*;
    logic        i_mclk, i_rst, i_wr, i_rd, i_odd_err, i_rate_event, i_pkt_valid;
    logic        i_ackid_mismatch, i_err_stop_clear, p_start, p_hold, lclk, o_irq;
    logic        o_pkt_ready, o_pkt_drop, o_pw_even, o_pw_odd, o_link_ok;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0]  sig, syn, lerr, p_err, p_sync;
    int          n_fail = 0, checks = 0, npw = 0, seed = 31, m_thr, k, n0;

    spe_partner u_prt (.i_start(p_start), .i_hold(p_hold), .i_err(p_err), .i_sync_on(p_sync),
        .o_signal(sig), .o_sync(syn), .o_err(lerr), .o_link_clk(lclk));
    spe_port #(.DEAD_CYC(20)) u_dut (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_lane_signal(sig), .i_lane_sync(syn), .i_lane_err(lerr),
        .i_link_clk(lclk), .i_odd_err, .i_rate_event, .i_ackid_mismatch, .i_err_stop_clear,
        .i_pkt_valid, .o_pkt_ready, .o_pkt_drop, .o_pw_even, .o_pw_odd, .o_link_ok, .o_irq);

    initial
    begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk)
        if (o_pw_even === 1'b1)
            npw <= npw + 1;

    task automatic final_report;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("ERROR %0t got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(negedge i_mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        chk(o_rdata & m, e);
    endtask
    task automatic pulse(input int s);
        @(posedge i_mclk);
        case (s)
            0: i_odd_err <= 1'b1;
            1: i_rate_event <= 1'b1;
            2: i_ackid_mismatch <= 1'b1;
            default: i_err_stop_clear <= 1'b1;
        endcase
        @(posedge i_mclk);
        {i_odd_err, i_rate_event, i_ackid_mismatch, i_err_stop_clear} <= 4'h0;
        @(negedge i_mclk);
    endtask
    function automatic logic pin(input int s);
        case (s)
            0: return o_link_ok;
            1: return o_pkt_drop;
            default: return o_pw_even & o_pw_odd;
        endcase
    endfunction
    task automatic wait_hi(input int s, input int n);
        int t;
        t = 0;
        while (pin(s) !== 1'b1 && t < n)
        begin
            @(negedge i_mclk);
            t++;
        end
        chk(pin(s), 1'b1);
    endtask

    initial
    begin
        {i_wr, i_rd, i_odd_err, i_rate_event, i_ackid_mismatch, i_err_stop_clear} = '0;
        {i_pkt_valid, p_start, p_hold, p_err, p_sync, i_addr, i_wdata} = '0;
        i_rst = 1'b1;
        repeat (16) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(SPE_ADDR_CTRL, 32'hff, 32'h01);
        rd(SPE_ADDR_THRESH, 32'hff, 32'hff);
        rd(SPE_ADDR_STATUS, 32'h3f, 32'h08);
        rd(8'h20, '1, 0);
        m_thr = $random(seed) & 8'hff;
        wr(SPE_ADDR_THRESH, m_thr);
        rd(SPE_ADDR_THRESH, 32'hff, m_thr);
        wr(SPE_ADDR_CTRL, 32'h81);
        pulse(0);
        wait_hi(2, 6);
        rd(SPE_ADDR_STATUS, 32'h30a, 32'h30a);
        rd(SPE_ADDR_DETECT, 32'h2, 32'h2);
        wr(SPE_ADDR_DETECT, 0);
        rd(SPE_ADDR_DETECT, 32'h2, 0);
        wr(SPE_ADDR_CTRL, 32'h83);
        wr(SPE_ADDR_STATUS, 32'h302);
        n0 = npw;
        pulse(0);
        tick(6);
        chk(npw - n0, 0);
        rd(SPE_ADDR_STATUS, 32'h202, 0);
        wr(SPE_ADDR_CTRL, 32'h81);
        wr(SPE_ADDR_DETECT, 0);
        for (k = 0; k < 4; k++)
        begin
            p_err <= 4'h1 << k;
            tick(6);
            rd(SPE_ADDR_DETECT, 32'h2, 0);
            p_sync <= 4'h1 << k;
            tick(6);
            rd(SPE_ADDR_DETECT, 32'h2, 32'h2);
            {p_err, p_sync} <= '0;
            tick(6);
            wr(SPE_ADDR_DETECT, 0);
        end
        wr(SPE_ADDR_STATUS, 32'h30b);
        rd(SPE_ADDR_STATUS, 32'h303, 0);
        wr(SPE_ADDR_CTRL, 32'h41);
        p_start <= 1'b1;
        wait_hi(0, 3000);
        p_start <= 1'b0;
        rd(SPE_ADDR_STATUS, 32'h1, 32'h1);
        rd(SPE_ADDR_DETECT, 32'h1, 32'h1);
        @(posedge i_mclk);
        i_pkt_valid <= 1'b1;
        tick(0);
        chk({o_pkt_ready, o_pkt_drop}, 2'b10);
        wr(SPE_ADDR_STATUS, 32'h1);
        wr(SPE_ADDR_DETECT, 0);
        rd(SPE_ADDR_STATUS, 32'h1, 0);
        rd(SPE_ADDR_DETECT, 32'h1, 0);
        wr(SPE_ADDR_CTRL, 32'h4d);
        m_thr = 1 + ($random(seed) & 7);
        wr(SPE_ADDR_THRESH, m_thr);
        wr(SPE_ADDR_RATE, 0);
        n0 = npw;
        repeat (m_thr) pulse(1);
        chk(o_pkt_drop, 0);
        pulse(1);
        tick(3);
        chk(npw - n0, 1);
        chk(o_pkt_drop, 1);
        rd(SPE_ADDR_RATE, 32'hff, m_thr + 1);
        pulse(2);
        chk(o_pkt_drop, 0);
        rd(SPE_ADDR_STATUS, 32'h10, 32'h10);
        pulse(3);
        chk(o_pkt_drop, 1);
        wr(SPE_ADDR_RATE, 0);
        wr(SPE_ADDR_CTRL, 32'h51);
        chk(o_pkt_drop, 0);
        p_hold <= 1'b1;
        wait_hi(1, 300);
        chk(o_link_ok, 0);
        wr(SPE_ADDR_CTRL, 32'h71);
        p_hold <= 1'b0;
        p_start <= 1'b1;
        wait_hi(0, 3000);
        p_start <= 1'b0;
        chk(o_pkt_drop, 1);
        wr(SPE_ADDR_CTRL, 32'h51);
        chk({o_pkt_ready, o_pkt_drop}, 2'b10);
        wr(SPE_ADDR_RATE, 32'hff);
        wr(SPE_ADDR_CTRL, 32'h4d);
        chk(o_pkt_drop, 1);
        rd(SPE_ADDR_IRQ_ST, 32'hf, 32'hf);
        wr(SPE_ADDR_IRQ_MSK, 32'hf);
        tick(2);
        chk(o_irq, 1);
        wr(SPE_ADDR_IRQ_ST, 32'hf);
        tick(2);
        chk(o_irq, 0);
        final_report;
    end

    initial
    begin
        repeat (30000) @(posedge i_mclk);
        n_fail++;
        final_report;
    end
endmodule
